// *** core/tbti_core.sv ***
// execution unit for counter test-and-branch and 8-bit table interpolation
// Operation
// - zero-test branch takes next-instruction address plus sign-extended offset when counter is zero.
// - non-zero-test branch is taken only when the counter is not zero.
// - three-byte instruction; displacement spans -256..+255 from the next instruction.
// - postbyte bits 2:0 pick A, B, D, X, Y or SP; 010 and 011 are invalid.
// - postbyte bit 5 picks branch sense; bit 3 is ignored.
// - postbyte bit 4 is the displacement sign above the offset byte.
// - postbyte bits 7:6 equal 01 test only; 00 decrements and 10 increments first; 11 is invalid.
// - decrement or increment the counter by one, then test the new value.
// - A gets Y1 plus fraction B times (Y2 minus Y1), unrounded, 8 bits.
// - B is an unsigned fraction with radix point left of its top bit.
// - first entry at effective address, second at effective address plus one.
// - product is 16 bits with radix between bits 7 and 8; integer part added.
// - table accepts only short constant or accumulator offset index forms.
// - after table, N is result top bit and Z is set for a zero result.
// - after table, C is set when the dropped fraction would round upward.
`timescale 1ns/1ps

module tbti_core
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     en_i,
	input  wire logic                     start_i,
	input  wire tbti_pkg::tbti_instr_type instr_i,
	input  wire tbti_pkg::tbti_regs_type  regs_i,
	input  wire logic [15:0]              ea_i,
	input  wire logic                     mem_ack_i,
	input  wire logic [7:0]               mem_rdata_i,
	output logic                          mem_req_o,
	output logic [15:0]                   mem_addr_o,
	output logic                          busy_o,
	output logic                          done_o,
	output logic                          illegal_o,
	output tbti_pkg::tbti_result_type     res_o
);
	import tbti_pkg::*;

	tbti_state_type  state_q;
	tbti_result_type res_q;
	logic            req_q;
	logic [15:0]     addr_q;
	logic            done_q;
	logic            illegal_q;
	logic [7:0]      y1_q;
	logic [7:0]      frac_q;
	logic [7:0]      flags_q;

	////////////////////////////////////////////////////////////////////////
	// instruction decode
	wire logic        idle_w    = (state_q == TBTI_IDLE);
	wire logic        loop_w    = start_i && idle_w && !instr_i.page2 && (instr_i.opcode == OPC_LOOP);
	wire logic        table_w   = start_i && idle_w && instr_i.page2 && (instr_i.opcode == OPC_TABLE);
	wire logic [7:0]  pb_w      = instr_i.postbyte;
	wire logic [2:0]  sel_w     = pb_w[LB_SEL_HI:0];
	wire logic [1:0]  op_w      = pb_w[LB_OP_HI:LB_OP_LO];
	// bit 3 never reaches any term below
	wire logic        sel_ok_w  = (sel_w != 3'b010) && (sel_w != 3'b011);
	wire logic        op_ok_w   = (op_w != 2'b11);
	wire logic        loop_ok_w = loop_w && sel_ok_w && op_ok_w;

	// short constant form, or accumulator offset without the indirect code
	wire logic        xb_const_w = !pb_w[XB_CONST_BIT];
	wire logic        xb_acc_w   = (pb_w[7:5] == XB_ACC_TAG) && pb_w[XB_ACC_BIT] && (pb_w[1:0] != XB_ACC_IND);
	wire logic        table_ok_w = table_w && (xb_const_w || xb_acc_w);

	////////////////////////////////////////////////////////////////////////
	// counter selection and update
	wire logic [15:0] cnt_raw_w =
		(sel_w == CNT_A) ? {8'h00, regs_i.a} :
		(sel_w == CNT_B) ? {8'h00, regs_i.b} :
		(sel_w == CNT_D) ? {regs_i.a, regs_i.b} :
		(sel_w == CNT_X) ? regs_i.x :
		(sel_w == CNT_Y) ? regs_i.y : regs_i.sp;
	wire logic        byte_w    = !sel_w[LB_SEL_HI];
	// step before the test so the branch sees the updated value
	wire logic [15:0] cnt_upd_w =
		(op_w == OP_DEC) ? cnt_raw_w - 16'h0001 :
		(op_w == OP_INC) ? cnt_raw_w + 16'h0001 : cnt_raw_w;
	// byte counters wrap within eight bits, not into the high byte
	wire logic [15:0] cnt_eff_w = byte_w ? {8'h00, cnt_upd_w[7:0]} : cnt_upd_w;
	wire logic        zero_w    = (cnt_eff_w == RST_WORD);
	wire logic        take_w    = pb_w[LB_SENSE_BIT] ? !zero_w : zero_w;

	// nine-bit displacement, sign from the postbyte
	wire logic [15:0] disp_w    = {{8{pb_w[LB_SIGN_BIT]}}, instr_i.offset};
	wire logic [15:0] next_pc_w = regs_i.pc + LOOP_LEN;
	wire logic [15:0] target_w  = next_pc_w + disp_w;

	////////////////////////////////////////////////////////////////////////
	// interpolation arithmetic, b taken as a fraction of 256
	wire logic signed [8:0]  diff_w   = $signed({1'b0, mem_rdata_i}) - $signed({1'b0, y1_q});
	wire logic signed [17:0] prod_w   = $signed({1'b0, frac_q}) * diff_w;
	wire logic [7:0]         interp_w = y1_q + prod_w[15:8];
	wire logic               round_w  = prod_w[7];
	wire logic               ack_lo_w = (state_q == TBTI_FETCH_LO) && mem_ack_i;
	wire logic               ack_hi_w = (state_q == TBTI_FETCH_HI) && mem_ack_i;
	// mask, half-carry and overflow pass through untouched
	wire logic [7:0]         tflags_w = {flags_q[7:4], interp_w[7], (interp_w == RST_BYTE), flags_q[FLAG_V], round_w};

	// loop and table results; flags written by the table result only
	wire tbti_result_type loop_res_w = '{pc_we: take_w, pc: target_w, cnt_we: (op_w != OP_TEST),
		cnt_sel: sel_w, cnt_val: cnt_eff_w, a_we: 1'b0, a: RST_BYTE, flags_we: 1'b0, flags: regs_i.flags};
	wire tbti_result_type tbl_res_w  = '{pc_we: 1'b0, pc: RST_WORD, cnt_we: 1'b0, cnt_sel: CNT_A,
		cnt_val: RST_WORD, a_we: 1'b1, a: interp_w, flags_we: 1'b1, flags: tflags_w};

	////////////////////////////////////////////////////////////////////////
	// sequencer; a low enable freezes everything, pulses included
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q   <= TBTI_IDLE;
			req_q     <= 1'b0;
			addr_q    <= RST_WORD;
			done_q    <= 1'b0;
			illegal_q <= 1'b0;
			res_q     <= RST_RESULT;
		end
		else if (en_i)
		begin
			done_q    <= 1'b0;
			illegal_q <= 1'b0;
			res_q     <= RST_RESULT;
			unique case (state_q)
				TBTI_IDLE:
				begin
					if (loop_ok_w)
					begin
						done_q <= 1'b1;
						res_q  <= loop_res_w;
					end
					else if (table_ok_w)
					begin
						state_q <= TBTI_FETCH_LO;
						req_q   <= 1'b1;
						addr_q  <= ea_i;
					end
					illegal_q <= (loop_w && !loop_ok_w) || (table_w && !table_ok_w);
				end
				TBTI_FETCH_LO:
				begin
					if (mem_ack_i)
					begin
						state_q <= TBTI_FETCH_HI;
						addr_q  <= addr_q + 16'h0001;
					end
				end
				TBTI_FETCH_HI:
				begin
					if (mem_ack_i)
					begin
						state_q <= TBTI_IDLE;
						req_q   <= 1'b0;
						done_q  <= 1'b1;
						res_q   <= tbl_res_w;
					end
				end
				// unused code 10: fall back to idle and drop the request
				default:
				begin
					state_q <= TBTI_IDLE;
					req_q   <= 1'b0;
				end
			endcase
		end
	end

	// operand capture: fraction and flags at start, first entry on its ack
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			y1_q    <= RST_BYTE;
			frac_q  <= RST_BYTE;
			flags_q <= RST_BYTE;
		end
		else if (en_i)
		begin
			if (table_ok_w)
			begin
				frac_q  <= regs_i.b;
				flags_q <= regs_i.flags;
			end
			if (ack_lo_w)
				y1_q <= mem_rdata_i;
		end
	end

	assign mem_req_o  = req_q;
	assign mem_addr_o = addr_q;
	assign busy_o     = req_q;
	assign done_o     = done_q;
	assign illegal_o  = illegal_q;
	assign res_o      = res_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// reference interpolation in wide integer arithmetic
	wire logic signed [31:0] ref_full_w = int'(y1_q) * 256 + int'(frac_q) * (int'(mem_rdata_i) - int'(y1_q));

	sequence table_start_s;
		en_i && table_ok_w;
	endsequence

	sequence fetch_first_s;
		mem_req_o && (mem_addr_o == $past(ea_i));
	endsequence

	sequence first_ack_s;
		en_i && ack_lo_w;
	endsequence

	sequence fetch_second_s;
		mem_req_o && (mem_addr_o == $past(mem_addr_o) + 16'h0001);
	endsequence

	zero_branch_a: assert property (en_i && loop_ok_w && !pb_w[LB_SENSE_BIT] |=>
		done_o && (res_o.pc_we == ($past(cnt_eff_w) == 16'h0000)))
		else $error("zero-test branch decision wrong");

	nonzero_branch_a: assert property (en_i && loop_ok_w && pb_w[LB_SENSE_BIT] |=>
		done_o && (res_o.pc_we == ($past(cnt_eff_w) != 16'h0000)))
		else $error("non-zero-test branch decision wrong");

	branch_target_a: assert property (en_i && loop_ok_w |=>
		res_o.pc == $past(regs_i.pc) + 16'h0003 + {{7{$past(pb_w[4])}}, $past(pb_w[4]), $past(instr_i.offset)})
		else $error("branch target not next address plus displacement");

	bad_counter_a: assert property (en_i && loop_w && (pb_w[2:1] == 2'b01) |=>
		illegal_o && !done_o && !res_o.cnt_we && !res_o.pc_we)
		else $error("unlisted counter code not refused");

	test_only_a: assert property (en_i && loop_ok_w && (op_w == 2'b01) |=> !res_o.cnt_we)
		else $error("test-only variant wrote the counter");

	dec_x_a: assert property (en_i && loop_ok_w && (op_w == 2'b00) && (sel_w == 3'b101) |=>
		res_o.cnt_we && (res_o.cnt_val == $past(regs_i.x) - 16'h0001))
		else $error("decrement of X wrong");

	inc_a_wrap_a: assert property (en_i && loop_ok_w && (op_w == 2'b10) && (sel_w == 3'b000) &&
		(regs_i.a == 8'hff) |=> res_o.cnt_val == 16'h0000 && (res_o.pc_we != $past(pb_w[5])))
		else $error("byte counter increment did not wrap to zero");

	fetch_pair_a: assert property (table_start_s |=> fetch_first_s)
		else $error("first table entry not fetched from ea");

	fetch_second_a: assert property (first_ack_s |=> fetch_second_s)
		else $error("second table entry not fetched from ea plus one");

	bad_index_a: assert property (en_i && table_w && pb_w[5] && (pb_w[7:5] != 3'b111) |=>
		illegal_o && !mem_req_o)
		else $error("excluded index form accepted");

	interp_value_a: assert property (en_i && ack_hi_w |=> done_o && res_o.a_we &&
		(res_o.a == $past(ref_full_w[15:8])) && (res_o.flags[0] == $past(ref_full_w[7])))
		else $error("interpolated result or carry wrong");

	table_flags_a: assert property (done_o && res_o.a_we |-> (res_o.flags[3] == res_o.a[7]) &&
		(res_o.flags[2] == (res_o.a == 8'h00)) && (res_o.flags[7:4] == flags_q[7:4]) && (res_o.flags[1] == flags_q[1]))
		else $error("table flags wrong");

	branch_flags_a: assert property (en_i && loop_ok_w |=> !res_o.flags_we && !res_o.a_we)
		else $error("branch touched flags");

endmodule

// *** dv/tb.sv ***
// self-checking bench for the test-branch and table-interpolate unit
`timescale 1ns/1ps

module tb;
	import tbti_pkg::*;
	logic            clk, rst, en, start, ack, req, busy, done, illegal;
	logic [1:0]      slow;
	logic [7:0]      rdata;
	logic [15:0]     ea, addr;
	tbti_instr_type  instr;
	tbti_regs_type   regs;
	tbti_result_type res;
	int              fail_count = 0;
	int              total_checks = 0;

	tbti_core dut_u (.clk_i(clk), .rst_i(rst), .en_i(en), .start_i(start), .instr_i(instr), .regs_i(regs),
		.ea_i(ea), .mem_ack_i(ack), .mem_rdata_i(rdata), .mem_req_o(req), .mem_addr_o(addr), .busy_o(busy),
		.done_o(done), .illegal_o(illegal), .res_o(res));
	tbti_mem_model mem_u (.clk_i(clk), .rst_i(rst), .req_i(req), .addr_i(addr), .wait_i(slow), .ack_o(ack),
		.rdata_o(rdata));

	////////////////////////////////////////////////////////////////////////////////
	// clock and watchdog; the run needs well under a thousand cycles
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		repeat (3000) @(posedge clk);
		fail_count++;
		$display("unexpected timeout");
		finish_test;
	end

	////////////////////////////////////////////////////////////////////////////////
	// comparison, verdict and expected-result helpers
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk_res(input tbti_result_type e);
		chk("done", 16'h1, {15'h0, done});
		chk("illegal", 16'h0, {15'h0, illegal});
		chk("pc_we", {15'h0, e.pc_we}, {15'h0, res.pc_we});
		if (e.pc_we)
			chk("pc", e.pc, res.pc);
		chk("cnt_we", {15'h0, e.cnt_we}, {15'h0, res.cnt_we});
		if (e.cnt_we)
		begin
			chk("cnt_sel", {13'h0, e.cnt_sel}, {13'h0, res.cnt_sel});
			chk("cnt", e.cnt_val, res.cnt_val);
		end
		chk("a_we", {15'h0, e.a_we}, {15'h0, res.a_we});
		if (e.a_we)
			chk("a", {8'h00, e.a}, {8'h00, res.a});
		chk("flags", {7'h0, e.flags_we, e.flags}, {7'h0, res.flags_we, res.flags});
	endtask

	// byte counters keep their upper byte clear, so a wrapped byte still tests as zero
	function automatic tbti_result_type loop_exp(input tbti_instr_type in, input tbti_regs_type r);
		tbti_result_type e;
		logic [15:0]     c;
		logic [8:0]      d;
		e = '0;
		case (in.postbyte[2:0])
			CNT_A: c = {8'h00, r.a};
			CNT_B: c = {8'h00, r.b};
			CNT_D: c = {r.a, r.b};
			CNT_X: c = r.x;
			CNT_Y: c = r.y;
			default: c = r.sp;
		endcase
		if (in.postbyte[7:6] != OP_TEST)
		begin
			c = (in.postbyte[7:6] == OP_DEC) ? c - 16'h0001 : c + 16'h0001;
			if (in.postbyte[2:1] == 2'b00)
				c[15:8] = 8'h00;
			e.cnt_we = 1'b1;
			e.cnt_sel = in.postbyte[2:0];
			e.cnt_val = c;
		end
		d = {in.postbyte[4], in.offset};
		e.pc_we = (c == 16'h0000) ^ in.postbyte[5];
		e.pc = r.pc + LOOP_LEN + {{7{d[8]}}, d};
		return e;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// every counter, sense and operation, issued back to back
	task automatic t_loop;
		logic [2:0]    sels [6] = '{CNT_A, CNT_B, CNT_D, CNT_X, CNT_Y, CNT_SP};
		logic [1:0]    ops [3] = '{OP_DEC, OP_TEST, OP_INC};
		tbti_instr_type in;
		tbti_regs_type  r;
		start = 1'b1;
		for (int i = 0; i < 72; i++)
		begin
			r = '0;
			r.pc = 16'h0100;
			if (i >= 36)
				r = '{8'hff, 8'h01, 16'h0001, 16'hffff, 16'h8000, 16'hfffe, 8'h00};
			in = '{1'b0, OPC_LOOP, {ops[(i / 12) % 3], 1'((i / 6) % 2), 1'(i % 2), 1'(i % 3 == 0), sels[i % 6]},
				8'(i * 37)};
			instr = in;
			regs = r;
			@(posedge clk);
			#1;
			chk_res(loop_exp(in, r));
		end
		start = 1'b0;
		@(posedge clk);
		#1;
		$display("loop test finished");
	endtask

	// unlisted counters and the unused operation code are refused without writes
	task automatic t_loop_bad;
		logic [7:0] pbs [3] = '{8'h42, 8'h63, 8'hc0};
		start = 1'b1;
		foreach (pbs[k])
		begin
			instr = '{1'b0, OPC_LOOP, pbs[k], 8'h10};
			@(posedge clk);
			#1;
			chk("illegal", 16'h1, {15'h0, illegal});
			chk("writes", 16'h0, {12'h0, done, res.pc_we, res.cnt_we, res.a_we});
		end
		start = 1'b0;
		@(posedge clk);
		#1;
		$display("loop refusal test finished");
	endtask

	// a low enable holds off issue and stretches the done pulse
	task automatic t_freeze;
		tbti_instr_type in;
		tbti_regs_type  r;
		r = '0;
		r.pc = 16'h0200;
		in = '{1'b0, OPC_LOOP, 8'h40, 8'h10};
		instr = in;
		regs = r;
		en = 1'b0;
		start = 1'b1;
		@(posedge clk);
		#1;
		chk("done frozen", 16'h0, {15'h0, done});
		en = 1'b1;
		@(posedge clk);
		#1;
		chk_res(loop_exp(in, r));
		en = 1'b0;
		start = 1'b0;
		@(posedge clk);
		#1;
		chk("done held", 16'h1, {15'h0, done});
		en = 1'b1;
		@(posedge clk);
		#1;
		chk("done after", 16'h0, {15'h0, done});
		$display("enable freeze test finished");
	endtask

	// table fetch straddles a 256-byte boundary; partner may stall
	task automatic t_table(input logic [7:0] y1, y2, b, xb, fl, input logic [1:0] w);
		tbti_result_type e;
		logic [15:0]     full;
		int              n;
		full = 16'(int'(y1) * 256 + int'(b) * (int'(y2) - int'(y1)));
		e = '0;
		e.a_we = 1'b1;
		e.a = full[15:8];
		e.flags_we = 1'b1;
		e.flags = {fl[7:4], full[15], full[15:8] == 8'h00, fl[1], full[7]};
		mem_u.mem[15] = y1;
		mem_u.mem[0] = y2;
		slow = w;
		regs = '0;
		regs.a = 8'h77;
		regs.b = b;
		regs.flags = fl;
		ea = 16'h10ff;
		instr = '{1'b1, OPC_TABLE, xb, 8'h00};
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		n = 0;
		for (int k = 0; k < 40 && done !== 1'b1; k++)
		begin
			if (ack)
			begin
				chk("addr", ea + 16'(n), addr);
				n++;
			end
			@(posedge clk);
			#1;
		end
		chk("acks", 16'h2, 16'(n));
		chk_res(e);
		$display("table test finished");
	endtask

	// excluded index forms give a refusal and no memory traffic
	task automatic t_table_bad;
		logic [7:0] xbs [3] = '{8'h20, 8'he7, 8'he0};
		start = 1'b1;
		foreach (xbs[k])
		begin
			instr = '{1'b1, OPC_TABLE, xbs[k], 8'h00};
			@(posedge clk);
			#1;
			chk("illegal", 16'h1, {15'h0, illegal});
			chk("req", 16'h0, {14'h0, req, done});
		end
		start = 1'b0;
		$display("table refusal test finished");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		rst = 1'b1;
		en = 1'b1;
		start = 1'b0;
		instr = '0;
		regs = '0;
		ea = 16'h0000;
		slow = 2'd0;
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		t_loop;
		t_loop_bad;
		t_freeze;
		t_table(8'd10, 8'd20, 8'h80, 8'h00, 8'hf2, 2'd0);
		t_table(8'hc8, 8'h32, 8'hff, 8'he4, 8'h0d, 2'd2);
		t_table(8'h00, 8'h00, 8'h7f, 8'he5, 8'h4a, 2'd1);
		t_table(8'hff, 8'hff, 8'h01, 8'hc3, 8'h00, 2'd0);
		t_table_bad;
		finish_test;
	end
endmodule

// *** dv/tbti_mem_model.sv ***
// data memory responder that answers the unit's table reads
`timescale 1ns/1ps

module tbti_mem_model
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [1:0]  wait_i,
	output logic             ack_o,
	output logic [7:0]       rdata_o
);
	logic [7:0] mem [0:15];
	logic [1:0] cnt_q;

	////////////////////////////////////////////////////////////////////////////////
	// ack after wait_i idle cycles; data flips when not valid so stale bytes never match
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ack_o   <= 1'b0;
			rdata_o <= 8'h5a;
			cnt_q   <= 2'h0;
		end
		else if (req_i && !ack_o && cnt_q == wait_i)
		begin
			ack_o   <= 1'b1;
			rdata_o <= mem[addr_i[3:0]];
			cnt_q   <= 2'h0;
		end
		else
		begin
			ack_o   <= 1'b0;
			rdata_o <= ~rdata_o;
			cnt_q   <= (req_i && !ack_o) ? cnt_q + 2'h1 : 2'h0;
		end
	end
endmodule

// *** include/tbti_pkg.sv ***
// shared constants and carrier types for the test-branch and table-interpolate unit
package tbti_pkg;

	// opcodes: loop family on page 1, table lookup on page 2
	localparam logic [7:0]  OPC_LOOP      = 8'h04;
	localparam logic [7:0]  OPC_TABLE     = 8'h3d;
	localparam logic [15:0] LOOP_LEN      = 16'h0003;

	// loop postbyte fields
	localparam int          LB_OP_HI      = 7;
	localparam int          LB_OP_LO      = 6;
	localparam int          LB_SENSE_BIT  = 5;
	localparam int          LB_SIGN_BIT   = 4;
	localparam int          LB_SEL_HI     = 2;
	localparam logic [1:0]  OP_DEC        = 2'b00;
	localparam logic [1:0]  OP_TEST       = 2'b01;
	localparam logic [1:0]  OP_INC        = 2'b10;
	localparam logic [2:0]  CNT_A         = 3'b000;
	localparam logic [2:0]  CNT_B         = 3'b001;
	localparam logic [2:0]  CNT_D         = 3'b100;
	localparam logic [2:0]  CNT_X         = 3'b101;
	localparam logic [2:0]  CNT_Y         = 3'b110;
	localparam logic [2:0]  CNT_SP        = 3'b111;

	// index postbyte field positions
	localparam int          XB_CONST_BIT  = 5;
	localparam int          XB_ACC_BIT    = 2;
	localparam logic [2:0]  XB_ACC_TAG    = 3'b111;
	localparam logic [1:0]  XB_ACC_IND    = 2'b11;

	// condition flag bit positions (S X H I N Z V C)
	localparam int          FLAG_N        = 3;
	localparam int          FLAG_Z        = 2;
	localparam int          FLAG_V        = 1;
	localparam int          FLAG_C        = 0;

	// reset values
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [7:0]  RST_BYTE      = 8'h00;

	typedef enum logic [1:0] {
		TBTI_IDLE     = 2'b00,
		TBTI_FETCH_LO = 2'b01,
		TBTI_FETCH_HI = 2'b11
	} tbti_state_type;

	typedef struct packed {
		logic        page2;
		logic [7:0]  opcode;
		logic [7:0]  postbyte;
		logic [7:0]  offset;
	} tbti_instr_type;

	typedef struct packed {
		logic [7:0]  a;
		logic [7:0]  b;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0]  flags;
	} tbti_regs_type;

	typedef struct packed {
		logic        pc_we;
		logic [15:0] pc;
		logic        cnt_we;
		logic [2:0]  cnt_sel;
		logic [15:0] cnt_val;
		logic        a_we;
		logic [7:0]  a;
		logic        flags_we;
		logic [7:0]  flags;
	} tbti_result_type;

	localparam tbti_result_type RST_RESULT = '0;

endpackage
